// *** core/ffp_core.sv ***
// Module: four phase fetch/execute pipeline control with 8-bit ALU
`timescale 1ns/100ps
module ffp_core #(
	parameter int PC_W = ffp_pkg::PC_WIDTH,   // Program counter width
	parameter int IW_W = ffp_pkg::WORD_WIDTH  // Instruction width
) (
	input  wire logic                i_clk,        // System clock
	input  wire logic                i_rstn,       // Async reset, active low
	input  wire logic [IW_W-1:0]     i_pmem_data,  // Program word, same cycle
	input  wire logic [7:0]          i_dmem_rdata, // Data memory read data
	input  wire logic [7:0]          i_ind_addr,   // Indirect pointer value
	output logic [PC_W-1:0]          o_pmem_addr,  // Program fetch address
	output logic                     o_pmem_rd,    // Fetch strobe in T1
	output ffp_pkg::ffp_dmem_type    o_dmem,       // Data memory request
	output logic [1:0]               o_phase,      // Current phase code
	output logic [7:0]               o_acc,        // Accumulator
	output logic                     o_zero,       // Zero status flag
	output logic                     o_carry,      // Carry status flag
	output logic                     o_dummy       // Dummy cycle in progress
);

	ffp_pkg::ffp_phase_type phase_q;   // Current phase
	logic [PC_W-1:0]        pc_q;      // Program counter
	logic [IW_W-1:0]        ir_q;      // Instruction under execution
	logic [IW_W-1:0]        fetch_q;   // Word prefetched during T1
	logic                   dummy_q;   // Current cycle is discarded
	logic                   flush_q;   // Request dummy next cycle
	logic [PC_W-1:0]        tgt_q;     // Pending branch target
	logic [7:0]             acc_q;     // Accumulator
	logic                   zf_q;      // Zero flag
	logic                   cf_q;      // Carry flag
	ffp_pkg::ffp_dmem_type  dm_q;      // Registered data request
	ffp_pkg::ffp_op_type    op;        // Decoded operation
	logic [7:0]             opnd;      // Memory operand
	logic [8:0]             alu;       // ALU result with carry
	logic                   wr_pc_low; // Store lands on PC low byte
	logic                   branch;    // Current op loads the PC
	logic [7:0]             eaddr;     // Effective data address

	// Decode fields: opcode in top four bits, ind flag, 8-bit address/imm
	assign op    = ffp_pkg::ffp_op_type'(ir_q[IW_W-1 -: 4]);
	assign eaddr = ir_q[8] ? i_ind_addr : ir_q[7:0];
	assign opnd  = (op == ffp_pkg::FFP_OP_LDA) ? ir_q[7:0] : i_dmem_rdata;
	assign wr_pc_low = (op == ffp_pkg::FFP_OP_MOVM) &&
			(eaddr == ffp_pkg::PC_LOW_ADDR);

	// Eight bit ALU shared by the arithmetic, logic, rotate, inc/dec, skip and load classes
	always_comb begin
		case (op)
		ffp_pkg::FFP_OP_ADD: alu = {1'b0, acc_q} + {1'b0, opnd};
		ffp_pkg::FFP_OP_SUB: alu = {1'b0, acc_q} - {1'b0, opnd};
		ffp_pkg::FFP_OP_AND: alu = {1'b0, acc_q & opnd};
		ffp_pkg::FFP_OP_OR:  alu = {1'b0, acc_q | opnd};
		ffp_pkg::FFP_OP_XOR: alu = {1'b0, acc_q ^ opnd};
		ffp_pkg::FFP_OP_RL:  alu = {opnd[7], opnd[6:0], opnd[7]};
		ffp_pkg::FFP_OP_RR:  alu = {opnd[0], opnd[0], opnd[7:1]};
		ffp_pkg::FFP_OP_INC: alu = {1'b0, opnd} + 9'h001;
		ffp_pkg::FFP_OP_DEC: alu = {1'b0, opnd} - 9'h001;
		ffp_pkg::FFP_OP_SZ:  alu = {1'b0, opnd};
		ffp_pkg::FFP_OP_LDA: alu = {1'b0, opnd};
		ffp_pkg::FFP_OP_MOVA: alu = {1'b0, opnd};
		default:             alu = {1'b0, acc_q};
		endcase
	end

	// Ops that redirect the PC need the extra cycle
	assign branch = !dummy_q && (op == ffp_pkg::FFP_OP_JMP ||
			op == ffp_pkg::FFP_OP_CALL || wr_pc_low ||
			(op == ffp_pkg::FFP_OP_SZ && alu[7:0] == 8'h00));

	// Phase ring, one instruction cycle per lap
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			phase_q <= ffp_pkg::FFP_T1;
		end else begin
			case (phase_q)
			ffp_pkg::FFP_T1: phase_q <= ffp_pkg::FFP_T2;
			ffp_pkg::FFP_T2: phase_q <= ffp_pkg::FFP_T3;
			ffp_pkg::FFP_T3: phase_q <= ffp_pkg::FFP_T4;
			default:         phase_q <= ffp_pkg::FFP_T1;
			endcase
		end
	end

	// PC and fetch: word taken at end of T1, executed in the next lap,
	// so the fetch of one word overlaps execution of the one before
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pc_q    <= PC_W'(ffp_pkg::RESET_VEC);
			fetch_q <= '0;
			ir_q    <= '0; // Runs as a no-op in the first lap
		end else if (phase_q == ffp_pkg::FFP_T4) begin
			// Branch target replaces sequential PC
			pc_q <= flush_q ? tgt_q : pc_q + PC_W'(1);
			ir_q <= fetch_q; // Prefetch goes to execute
		end else if (phase_q == ffp_pkg::FFP_T1) begin
			fetch_q <= i_pmem_data;
		end
	end

	// Branch detect in T3; dummy marks the next cycle as discarded
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			flush_q <= 1'b0;
			tgt_q   <= '0;
			dummy_q <= 1'b0;
		end else if (phase_q == ffp_pkg::FFP_T3) begin
			flush_q <= branch;
			if (wr_pc_low) begin
				// Only low byte moves; page kept
				tgt_q <= {pc_q[PC_W-1:8], acc_q};
			end else if (op == ffp_pkg::FFP_OP_SZ) begin
				tgt_q <= pc_q + PC_W'(1);
			end else begin
				tgt_q <= PC_W'(ir_q[IW_W-5:0]);
			end
		end else if (phase_q == ffp_pkg::FFP_T4) begin
			dummy_q <= flush_q;
			flush_q <= 1'b0;
		end
	end

	// Execute: writes land in T4, never in a dummy cycle
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			acc_q <= ffp_pkg::ACC_RESET;
			zf_q  <= 1'b0;
			cf_q  <= 1'b0;
			dm_q  <= '0;
		end else begin
			dm_q.we <= 1'b0;
			if (phase_q == ffp_pkg::FFP_T2) begin
				dm_q.addr <= eaddr;
				dm_q.ind  <= ir_q[8];
			end
			if (phase_q == ffp_pkg::FFP_T4 && !dummy_q) begin
				case (op)
				ffp_pkg::FFP_OP_NOP, ffp_pkg::FFP_OP_JMP,
				ffp_pkg::FFP_OP_CALL, ffp_pkg::FFP_OP_SZ: ;
				ffp_pkg::FFP_OP_MOVM: begin
					// PC low byte store is handled as branch
					dm_q.we    <= !wr_pc_low;
					dm_q.wdata <= acc_q;
				end
				ffp_pkg::FFP_OP_INC, ffp_pkg::FFP_OP_DEC,
				ffp_pkg::FFP_OP_RL, ffp_pkg::FFP_OP_RR: begin
					dm_q.we    <= 1'b1;
					dm_q.wdata <= alu[7:0];
					zf_q       <= (alu[7:0] == 8'h00);
				end
				default: begin
					acc_q <= alu[7:0];
					zf_q  <= (alu[7:0] == 8'h00);
					cf_q  <= alu[8];
				end
				endcase
			end
		end
	end

	assign o_pmem_addr = pc_q;
	assign o_pmem_rd   = (phase_q == ffp_pkg::FFP_T1);
	assign o_dmem      = dm_q;
	assign o_phase     = phase_q;
	assign o_acc       = acc_q;
	assign o_zero      = zf_q;
	assign o_carry     = cf_q;
	assign o_dummy     = dummy_q;

	// Phase ring walks T1..T4 in order
	phase_ring_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		phase_q == ffp_pkg::FFP_T1 |=> phase_q == ffp_pkg::FFP_T2 ##1
		phase_q == ffp_pkg::FFP_T3 ##1 phase_q == ffp_pkg::FFP_T4 ##1
		phase_q == ffp_pkg::FFP_T1)
		else $error("phase ring out of order");
	// PC steps once per cycle when no branch
	pc_step_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		phase_q == ffp_pkg::FFP_T4 && !flush_q |=>
		pc_q == $past(pc_q) + PC_W'(1))
		else $error("pc did not step");
	// Word fetched in T1 is the one executed in the next lap
	fetch_t1_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_pmem_rd |-> ##4 ir_q == $past(i_pmem_data, 4))
		else $error("fetched word not executed next");
	// Branch in T3 gives dummy for following cycle
	branch_dummy_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		phase_q == ffp_pkg::FFP_T3 && branch |=> ##1 dummy_q [*4])
		else $error("branch without dummy cycle");
	// Dummy cycle writes no memory, accumulator or zero flag
	dummy_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		dummy_q && phase_q == ffp_pkg::FFP_T4 |=>
		!dm_q.we && $stable(acc_q) && $stable(zf_q))
		else $error("dummy cycle updated state");
	// Low byte write keeps the page
	pc_low_page_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		phase_q == ffp_pkg::FFP_T3 && wr_pc_low && !dummy_q |=> ##1
		pc_q[PC_W-1:8] == $past(pc_q[PC_W-1:8], 2))
		else $error("pc low write left page");
	// Skip taken discards next word
	skip_dummy_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		phase_q == ffp_pkg::FFP_T3 && !dummy_q &&
		op == ffp_pkg::FFP_OP_SZ && alu[7:0] == 8'h00 |=> flush_q)
		else $error("skip did not flush");
	// Executes only in T4 update the accumulator
	acc_t4_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		!$stable(acc_q) |-> $past(phase_q) == ffp_pkg::FFP_T4)
		else $error("accumulator changed outside T4");

endmodule : ffp_core

// *** core/ffp_pkg.sv ***
// Package: constants and carrier types for the fetch/execute pipeline core
package ffp_pkg;

	localparam int          PC_WIDTH    = 11;            // Program counter bits
	localparam int          WORD_WIDTH  = 15;            // Instruction word bits
	localparam int          DATA_WIDTH  = 8;             // ALU data width
	localparam logic [10:0] RESET_VEC   = 11'h000;       // Reset entry address
	localparam logic [7:0]  ACC_RESET   = 8'h00;         // Accumulator at reset
	localparam logic [7:0]  PC_LOW_ADDR = 8'h06;         // Data address of PC low byte

	// Four phases, gray coded around the ring
	typedef enum logic [1:0] {
		FFP_T1 = 2'b00,
		FFP_T2 = 2'b01,
		FFP_T3 = 2'b11,
		FFP_T4 = 2'b10
	} ffp_phase_type;

	// Execute operation classes decoded from the upper opcode bits
	typedef enum logic [3:0] {
		FFP_OP_NOP   = 4'h0,
		FFP_OP_ADD   = 4'h1,
		FFP_OP_SUB   = 4'h2,
		FFP_OP_AND   = 4'h3,
		FFP_OP_OR    = 4'h4,
		FFP_OP_XOR   = 4'h5,
		FFP_OP_RL    = 4'h6,
		FFP_OP_RR    = 4'h7,
		FFP_OP_INC   = 4'h8,
		FFP_OP_DEC   = 4'h9,
		FFP_OP_MOVA  = 4'ha,
		FFP_OP_MOVM  = 4'hb,
		FFP_OP_SZ    = 4'hc,
		FFP_OP_JMP   = 4'hd,
		FFP_OP_LDA   = 4'he,
		FFP_OP_CALL  = 4'hf
	} ffp_op_type;

	// Data memory request from the core toward the data memory
	typedef struct packed {
		logic       we;
		logic       ind;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ffp_dmem_type;

endpackage : ffp_pkg

// *** verification/ffp_mem_model.sv ***
// Program and data memory model facing the pipeline core
`timescale 1ns/100ps
module ffp_mem_model (
	input  wire logic                  i_clk,        // System clock
	input  wire logic [10:0]           i_pmem_addr,  // Fetch address
	input  wire logic                  i_pmem_rd,    // Fetch strobe
	input  wire ffp_pkg::ffp_dmem_type i_dmem,       // Data request
	output logic [14:0]                o_pmem_data,  // Program word
	output logic [7:0]                 o_dmem_rdata  // Data read value
);
	logic [14:0] prog [2048];  // Program words
	logic [7:0]  data [256];   // Data bytes
	logic [14:0] last_q;       // Last word fetched
	// Off-fetch the bus shows junk so a late sample cannot pass
	assign o_pmem_data  = i_pmem_rd ? prog[i_pmem_addr] : ~last_q;
	assign o_dmem_rdata = data[i_dmem.addr];
	// Remember word, store on write pulse
	always @(posedge i_clk) begin
		if (i_pmem_rd)
			last_q <= prog[i_pmem_addr];
		if (i_dmem.we)
			data[i_dmem.addr] <= i_dmem.wdata;
	end
endmodule : ffp_mem_model

// *** verification/four_phase_fetch_execute_pipeline_tb_top.sv ***
// Testbench: program run through the pipeline core
`timescale 1ns/100ps
module four_phase_fetch_execute_pipeline_tb_top;
	logic                  i_clk, i_rstn;  // Clock and reset
	logic [7:0]            i_ind_addr;     // Random pointer
	logic [14:0]           pdata;          // Program word
	logic [7:0]            rdata, acc;     // Read data, accumulator
	logic [10:0]           pc;             // Fetch address
	logic [1:0]            phase;          // Phase code
	logic                  rd, zf, cf, dm; // Strobe, flags, dummy
	ffp_pkg::ffp_dmem_type dmem;           // Data request
	int err_total, compares, cyc, i;       // Counters
	logic [31:0] seed;                     // Random state
	logic [7:0]  r1, r2;                   // Random operands
	logic [7:0]  ptr;                      // Indirect pointer, clear of used data
	logic [8:0]  sum;                      // Sum with carry
	logic [10:0] epc [13];                 // Expected fetch addresses
	logic [12:0] edm;                      // Expected dummy cycles

	ffp_core DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_pmem_data(pdata),
		.i_dmem_rdata(rdata), .i_ind_addr(i_ind_addr), .o_pmem_addr(pc),
		.o_pmem_rd(rd), .o_dmem(dmem), .o_phase(phase), .o_acc(acc),
		.o_zero(zf), .o_carry(cf), .o_dummy(dm));
	ffp_mem_model MEM (.i_clk(i_clk), .i_pmem_addr(pc), .i_pmem_rd(rd),
		.i_dmem(dmem), .o_pmem_data(pdata), .o_dmem_rdata(rdata));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction : xs
	// Instruction word from operation class and 11-bit field
	function automatic logic [14:0] mk(input ffp_pkg::ffp_op_type op,
		input logic [10:0] v);
		return {op, v};
	endfunction : mk
	task automatic bad(input string m);
		err_total++;
		$display("wrong value at %0t: %s", $time, m);
	endtask : bad
	task automatic chk_addr(input logic [10:0] g, e);
		compares++;
		if (g !== e) bad("address");
	endtask : chk_addr
	task automatic chk_byte(input logic [7:0] g, e);
		compares++;
		if (g !== e) bad("data byte");
	endtask : chk_byte
	task automatic chk_bit(input logic g, e);
		compares++;
		if (g !== e) bad("flag");
	endtask : chk_bit
	task automatic results;
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results

	initial begin
		i_clk = 0;
		forever #5 i_clk = ~i_clk;
	end
	// Hang guard
	always @(posedge i_clk) begin
		cyc++;
		i_ind_addr <= ptr;
		if (cyc == 300) begin
			err_total++;
			results();
		end
	end

	initial begin
		i_rstn = 0;
		seed = 32'h7959_ceb0;
		seed = xs(seed);
		r1 = seed[7:0];
		seed = xs(seed);
		r2 = seed[7:0];
		sum = r1 + r2;
		ptr = {2'b10, seed[13:8]};
		MEM.data[8'h20] = r2;
		MEM.data[8'h21] = 8'h00;
		MEM.prog[11'h000] = mk(ffp_pkg::FFP_OP_LDA, {3'h0, r1});
		MEM.prog[11'h001] = mk(ffp_pkg::FFP_OP_JMP, 11'h010);
		MEM.prog[11'h002] = mk(ffp_pkg::FFP_OP_LDA, 11'h0ff);
		MEM.prog[11'h010] = mk(ffp_pkg::FFP_OP_ADD, 11'h020);
		MEM.prog[11'h011] = mk(ffp_pkg::FFP_OP_SZ, 11'h021);
		MEM.prog[11'h012] = mk(ffp_pkg::FFP_OP_LDA, 11'h055);
		// Store through the pointer input
		MEM.prog[11'h013] = mk(ffp_pkg::FFP_OP_MOVM, 11'h122);
		MEM.prog[11'h014] = mk(ffp_pkg::FFP_OP_LDA, 11'h030);
		MEM.prog[11'h015] = mk(ffp_pkg::FFP_OP_MOVM, 11'h006);
		MEM.prog[11'h016] = mk(ffp_pkg::FFP_OP_LDA, 11'h077);
		MEM.prog[11'h030] = mk(ffp_pkg::FFP_OP_JMP, 11'h030);
		MEM.prog[11'h031] = mk(ffp_pkg::FFP_OP_LDA, 11'h011);
		epc = '{11'h000, 11'h001, 11'h002, 11'h010, 11'h011, 11'h012,
			11'h013, 11'h014, 11'h015, 11'h016, 11'h030, 11'h031, 11'h030};
		// Dummy lap is the one that runs the discarded prefetched word
		edm = 13'h1448;
		// Release off the edge so no check starts on a reset sample
		repeat (4) @(negedge i_clk);
		i_rstn <= 1;
		for (i = 0; i < 13; i++) begin
			chk_addr(pc, epc[i]);
			chk_bit(rd, 1'b1);
			if (i == 0)
				chk_byte(acc, ffp_pkg::ACC_RESET);
			if (i == 5)
				chk_byte(acc, sum[7:0]);
			if (i == 5)
				chk_bit(cf, sum[8]);
			if (i == 5)
				chk_bit(zf, sum[7:0] == 8'h00);
			if (i == 4 || i == 8)
				chk_byte(acc, i == 4 ? r1 : sum[7:0]);
			if (i == 12)
				chk_byte(acc, 8'h30);
			@(negedge i_clk);
			chk_bit(dm, edm[i]);
			chk_addr({9'h000, phase}, {9'h000, ffp_pkg::FFP_T2});
			chk_bit(rd, 1'b0);
			repeat (2) @(negedge i_clk);
			chk_addr({9'h000, phase}, {9'h000, ffp_pkg::FFP_T4});
			@(negedge i_clk);
		end
		chk_byte(MEM.data[ptr], sum[7:0]);
		results();
	end
endmodule : four_phase_fetch_execute_pipeline_tb_top
